// ===== design/sdma_params.svh
`ifndef SDMA_PARAMS_SVH
`define SDMA_PARAMS_SVH
// Behaviour
// - Six channels, each with its own context.
// - Controller beats CPU for internal memory.
// - One external-read and one external-write channel only.
// - External write at least 9, read 13 cycles.
// - Bus owner stalls other; controller beats CPU I/O.
// - Hold grant waits for pending controller transfers.
// - No bursts; re-arbitrate every external bus cycle.
// - External: single words; unsupported combinations refused.
// - Hold mode 0 keeps running, 1 halts.
// - Mode bits 5 and 11 select external.
// - Two 7-bit extended pages at 028h, 029h.
// - Address map ignores CPU memory configuration bits.
// - Per-channel high/low priority, round-robin within level.
// - Addresses held, incremented, decremented or indexed.
// - Auto_reinit_enable reloads addresses and counts from globals.
// - 8-bit frame counter decrements on last read.
// - 16-bit element counter decrements per element read.
// - Double-word: two internal transfers, one element.
// - Element index adjusts all but last transfer.
// - Frame index adjusts last transfer of frame.
// - Enable bit gates interrupts; buffering full/half events.
// - Multi-frame interrupts: block end, or frames too.
// - 4-bit sync field picks each transfer's trigger.
`define SDMA_NCH 6
`define SDMA_REG_MAIN 8'h54
`define SDMA_REG_SBA 8'h55
`define SDMA_REG_SBD 8'h56
`define SDMA_REG_SBDI 8'h57
`define SDMA_SB_CH_END 6'h1E
`define SDMA_SB_GLB 6'h20
`define SDMA_SB_GLB_END 6'h27
`define SDMA_SB_XSRC 6'h28
`define SDMA_SB_XDST 6'h29
`define SDMA_SB_STAT 6'h2A
`define SDMA_SB_REGS 6'h05
`define SDMA_F_SRC 3'd0
`define SDMA_F_DST 3'd1
`define SDMA_F_CTR 3'd2
`define SDMA_F_SFC 3'd3
`define SDMA_F_MCR 3'd4
`define SDMA_G_IDX0 3'd0
`define SDMA_G_IDX1 3'd1
`define SDMA_G_FRI0 3'd2
`define SDMA_G_FRI1 3'd3
`define SDMA_G_GSA 3'd4
`define SDMA_G_GDA 3'd5
`define SDMA_G_GCR 3'd6
`define SDMA_G_GFR 3'd7
`define SDMA_IX_INC 3'd1
`define SDMA_IX_DEC 3'd2
`define SDMA_IX_SEL0 3'd3
`define SDMA_IX_SEL1 3'd4
`define SDMA_SYNC_NONE 4'h0
`define SDMA_EXT_WR_MIN 4'd9
`define SDMA_EXT_RD_MIN 4'd13
`endif

// ===== design/sdma_pkg.sv
`include "sdma_params.svh"
package sdma_pkg;
  typedef enum logic [1:0] {ENG_IDLE, ENG_READ, ENG_WRITE} sdma_eng_t;
  typedef enum logic [1:0] {BUS_FREE, BUS_DMA, BUS_CPU, BUS_HOLD} sdma_bus_t;
  // Channel mode control word, bit 15 first.
  typedef struct packed {
    logic auto_reinit_enable;
    logic interrupt_enable_bit;
    logic interrupt_mode_bit;
    logic auto_buffering_mode;
    logic src_external_select;
    logic [2:0] source_index_select;
    logic [1:0] spare_hi;
    logic dest_external_select;
    logic [2:0] dest_index_select;
    logic spare_lo;
    logic double_word;
  } sdma_mcr_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } sdma_mem_req_t;
  typedef struct packed {
    logic stb;
    logic we;
    logic [6:0] page;
    logic [15:0] addr;
    logic [15:0] wdata;
  } sdma_ext_req_t;
  typedef struct packed {
    logic hit;
    logic [2:0] ch;
    logic [2:0] fld;
  } sdma_sb_t;
  typedef struct packed {
    logic [`SDMA_NCH-1:0][15:0] src, dst, ctr, sfc;
    sdma_mcr_t [`SDMA_NCH-1:0] mcr;
    logic [7:0][15:0] glb;
    logic [6:0] xsrc, xdst;
    logic [`SDMA_NCH-1:0] en, hipri, pend, ints;
    logic [5:0] sba;
    logic [15:0] rdata;
    sdma_eng_t eng;
    sdma_bus_t bus;
    logic [2:0] ch, last_ch;
    logic half, lastf, reload_dst;
    logic [1:0][15:0] bdat;
    logic bwp, brp;
    logic [1:0] bcnt;
    logic [3:0] bcyc;
    logic [2:0] hsync;
    logic hold_lvl;
  } sdma_state_t;
endpackage : sdma_pkg

// ===== design/sdma_ctrl.sv
`timescale 1ns/100ps
`include "sdma_params.svh"
module sdma_ctrl (
  input wire logic CLK_I, // 25 MHz clock.
  input wire logic SYS_RST_I, // Synchronous reset.
  input wire logic [7:0] REG_ADDR_I, // Register address.
  input wire logic REG_WR_I, // Write strobe.
  input wire logic REG_RD_I, // Read strobe.
  input wire logic [15:0] REG_WDATA_I, // Write data.
  output logic [15:0] REG_RDATA_O, // Read data, next cycle.
  input wire logic CPU_INT_REQ_I, // CPU internal access request.
  output logic CPU_INT_WAIT_O, // CPU internal wait state.
  output sdma_pkg::sdma_mem_req_t INT_REQ_O, // Internal memory request.
  input wire logic INT_ACK_I, // Internal access done.
  input wire logic [15:0] INT_RDATA_I, // Internal read data.
  output sdma_pkg::sdma_ext_req_t EXT_REQ_O, // External bus cycle.
  input wire logic EXT_RDY_I, // External memory ready.
  input wire logic [15:0] EXT_RDATA_I, // External read data.
  input wire logic CPU_XIO_REQ_I, // CPU external I/O request.
  output logic CPU_XIO_GNT_O, // CPU owns external bus.
  output logic CPU_XIO_WAIT_O, // CPU external wait state.
  input wire logic BUS_HOLD_REQ_I, // Hold request pin.
  output logic BUS_HOLD_GRANT_O, // Bus hold grant.
  input wire logic HOLD_MODE_BIT_I, // Hold mode bit of CPU status.
  output logic CPU_HALT_O, // Halt CPU while held.
  input wire logic [15:0] SYNC_EVT_I, // Sync event pulses by code.
  output logic [`SDMA_NCH-1:0] CH_INT_O // Channel interrupt pulses.
);
  sdma_pkg::sdma_state_t s_r, s_nxt;
  sdma_pkg::sdma_mcr_t cm;
  logic [`SDMA_NCH-1:0] srcx, dstx, blocked, ready, hi;
  logic [2:0] xrd, xwr, pick_ch;
  logic buf_full, buf_empty, ext_need, ext_done, rd_done, wr_done, last_el, hold_ok, ie_cur;
  logic [3:0] ext_min;
  logic [15:0] rd_word, ctr_cur;
  logic [7:0] frc_cur;

  // Round-robin pick: first set bit after the last served channel.
  function automatic logic [2:0] rr_pick(input logic [5:0] m, input logic [2:0] last);
    logic [2:0] r;
    int j;
    r = last;
    for (int k = 6; k >= 1; k--) begin
      j = (int'(last) + k) % 6;
      if (m[j]) r = 3'(j);
    end
    return r;
  endfunction : rr_pick

  // Lowest set bit; used for both external channel slots.
  function automatic logic [2:0] first_set(input logic [5:0] m);
    logic [2:0] r;
    r = 3'd0;
    for (int i = 5; i >= 0; i--) begin
      if (m[i]) r = 3'(i);
    end
    return r;
  endfunction : first_set

  // Post-access address step.
  function automatic logic [15:0] step(input logic [2:0] sel, input logic last, input logic [7:0][15:0] g);
    case (sel)
      `SDMA_IX_INC: step = 16'h0001;
      `SDMA_IX_DEC: step = 16'hFFFF;
      `SDMA_IX_SEL0: step = last ? g[`SDMA_G_FRI0] : g[`SDMA_G_IDX0];
      `SDMA_IX_SEL1: step = last ? g[`SDMA_G_FRI1] : g[`SDMA_G_IDX1];
      default: step = 16'h0000;
    endcase
  endfunction : step

  // Subbank pointer decode, for reads and writes.
  function automatic sdma_pkg::sdma_sb_t sb_dec(input logic [5:0] a);
    sb_dec.hit = a < `SDMA_SB_CH_END;
    sb_dec.ch = 3'(a / `SDMA_SB_REGS);
    sb_dec.fld = 3'(a % `SDMA_SB_REGS);
  endfunction : sb_dec

  // Channel eligibility. Unsupported external combinations never run.
  for (genvar g = 0; g < `SDMA_NCH; g++) begin : g_ch
    assign srcx[g] = s_r.en[g] & s_r.mcr[g].src_external_select;
    assign dstx[g] = s_r.en[g] & s_r.mcr[g].dest_external_select;
    assign blocked[g] = (srcx[g] & dstx[g])
      | ((srcx[g] | dstx[g]) & ((s_r.sfc[g][15:12] != `SDMA_SYNC_NONE) | s_r.mcr[g].double_word))
      | (srcx[g] & (xrd != 3'(g))) | (dstx[g] & (xwr != 3'(g)));
    assign ready[g] = s_r.en[g] & ~blocked[g]
      & ((s_r.sfc[g][15:12] == `SDMA_SYNC_NONE) | s_r.pend[g]);
  end
  assign xrd = first_set(srcx);
  assign xwr = first_set(dstx);
  assign hi = ready & s_r.hipri;
  assign pick_ch = (|hi) ? rr_pick(hi, s_r.last_ch) : rr_pick(ready, s_r.last_ch);

  // Current channel view and buffer levels.
  assign cm = s_r.mcr[s_r.ch];
  assign ctr_cur = s_r.ctr[s_r.ch];
  assign frc_cur = s_r.sfc[s_r.ch][7:0];
  assign ie_cur = cm.interrupt_enable_bit;
  assign buf_full = s_r.bcnt == 2'd2;
  assign buf_empty = s_r.bcnt == 2'd0;
  assign last_el = (ctr_cur == 16'h0000) && (!cm.double_word || s_r.half);

  // Requests. Addresses go out untranslated, whatever the CPU memory setup.
  assign INT_REQ_O.we = s_r.eng == sdma_pkg::ENG_WRITE;
  assign INT_REQ_O.addr = INT_REQ_O.we ? s_r.dst[s_r.ch] : s_r.src[s_r.ch];
  assign INT_REQ_O.wdata = s_r.bdat[s_r.brp];
  assign INT_REQ_O.req = (s_r.eng == sdma_pkg::ENG_READ && !cm.src_external_select && !buf_full)
    || (s_r.eng == sdma_pkg::ENG_WRITE && !cm.dest_external_select && !buf_empty);
  assign CPU_INT_WAIT_O = CPU_INT_REQ_I & INT_REQ_O.req;
  assign ext_need = (s_r.eng == sdma_pkg::ENG_READ && cm.src_external_select && !buf_full)
    || (s_r.eng == sdma_pkg::ENG_WRITE && cm.dest_external_select && !buf_empty);
  assign EXT_REQ_O.stb = s_r.bus == sdma_pkg::BUS_DMA;
  assign EXT_REQ_O.we = INT_REQ_O.we;
  assign EXT_REQ_O.page = EXT_REQ_O.we ? s_r.xdst : s_r.xsrc;
  assign EXT_REQ_O.addr = INT_REQ_O.addr;
  assign EXT_REQ_O.wdata = INT_REQ_O.wdata;
  // The strobe holds until both the floor count and the memory agree.
  assign ext_min = EXT_REQ_O.we ? `SDMA_EXT_WR_MIN - 4'd1 : `SDMA_EXT_RD_MIN - 4'd1;
  assign ext_done = EXT_REQ_O.stb && EXT_RDY_I && (s_r.bcyc >= ext_min);
  assign rd_done = s_r.eng == sdma_pkg::ENG_READ
    && (cm.src_external_select ? ext_done : (INT_REQ_O.req && INT_ACK_I));
  assign wr_done = s_r.eng == sdma_pkg::ENG_WRITE
    && (cm.dest_external_select ? ext_done : (INT_REQ_O.req && INT_ACK_I));
  assign rd_word = cm.src_external_select ? EXT_RDATA_I : INT_RDATA_I;
  // Hold waits while a channel with external work is in flight.
  assign hold_ok = s_r.hold_lvl
    && !(s_r.eng != sdma_pkg::ENG_IDLE && (cm.src_external_select || cm.dest_external_select));
  assign CPU_XIO_GNT_O = s_r.bus == sdma_pkg::BUS_CPU;
  assign CPU_XIO_WAIT_O = CPU_XIO_REQ_I & ~CPU_XIO_GNT_O;
  assign BUS_HOLD_GRANT_O = s_r.bus == sdma_pkg::BUS_HOLD;
  assign CPU_HALT_O = BUS_HOLD_GRANT_O & HOLD_MODE_BIT_I;
  assign REG_RDATA_O = s_r.rdata;
  assign CH_INT_O = s_r.ints;

  // Next state of the whole block.
  always_comb begin
    sdma_pkg::sdma_sb_t sb;
    logic [2:0] c;
    logic [15:0] rv;
    s_nxt = s_r;
    sb = sb_dec(s_r.sba);
    c = s_r.ch;
    rv = 16'h0000;
    s_nxt.ints = '0;
    // Hold pin: three stages, a change counts once stages two and three agree.
    s_nxt.hsync = {s_r.hsync[1:0], BUS_HOLD_REQ_I};
    if (s_r.hsync[1] == s_r.hsync[2]) s_nxt.hold_lvl = s_r.hsync[2];
    // Sync events latch; a new event wins over the clear at service.
    for (int i = 0; i < `SDMA_NCH; i++) begin
      if (s_r.eng == sdma_pkg::ENG_IDLE && (|ready) && pick_ch == 3'(i)) s_nxt.pend[i] = 1'b0;
      if (s_r.sfc[i][15:12] != `SDMA_SYNC_NONE && SYNC_EVT_I[s_r.sfc[i][15:12]]) s_nxt.pend[i] = 1'b1;
    end
    // External bus owner. Every access returns to free so all parties are weighed again.
    case (s_r.bus)
      sdma_pkg::BUS_FREE: begin
        s_nxt.bcyc = 4'h0;
        if (ext_need) s_nxt.bus = sdma_pkg::BUS_DMA;
        else if (hold_ok) s_nxt.bus = sdma_pkg::BUS_HOLD;
        else if (CPU_XIO_REQ_I) s_nxt.bus = sdma_pkg::BUS_CPU;
      end
      sdma_pkg::BUS_DMA: begin
        if (s_r.bcyc != 4'hF) s_nxt.bcyc = s_r.bcyc + 4'd1;
        if (ext_done) s_nxt.bus = sdma_pkg::BUS_FREE;
      end
      sdma_pkg::BUS_CPU: if (!CPU_XIO_REQ_I) s_nxt.bus = sdma_pkg::BUS_FREE;
      sdma_pkg::BUS_HOLD: if (!s_r.hold_lvl) s_nxt.bus = sdma_pkg::BUS_FREE;
      default: s_nxt.bus = sdma_pkg::BUS_FREE;
    endcase
    // Two-entry buffer between read and write; a stalled write holds the word.
    s_nxt.bcnt = s_r.bcnt + {1'b0, rd_done} - {1'b0, wr_done};
    // Transfer engine: one element per service, then arbitration again.
    case (s_r.eng)
      sdma_pkg::ENG_IDLE: if (|ready) begin
        s_nxt.ch = pick_ch;
        s_nxt.half = 1'b0;
        s_nxt.eng = sdma_pkg::ENG_READ;
      end
      sdma_pkg::ENG_READ: if (rd_done) begin
        s_nxt.bdat[s_r.bwp] = rd_word;
        s_nxt.bwp = ~s_r.bwp;
        s_nxt.lastf = last_el;
        s_nxt.src[c] = s_r.src[c] + step(cm.source_index_select, last_el, s_r.glb);
        s_nxt.eng = sdma_pkg::ENG_WRITE;
        if (!cm.double_word || s_r.half) begin
          if (ctr_cur != 16'h0000) begin
            s_nxt.ctr[c] = ctr_cur - 16'h0001;
            if (cm.auto_buffering_mode && ie_cur && cm.interrupt_mode_bit
                && s_nxt.ctr[c] == {1'b0, s_r.glb[`SDMA_G_GCR][15:1]}) s_nxt.ints[c] = 1'b1;
          end else begin
            s_nxt.ctr[c] = s_r.glb[`SDMA_G_GCR];
            if (frc_cur != 8'h00 && !cm.auto_buffering_mode) begin
              s_nxt.sfc[c][7:0] = frc_cur - 8'h01;
              if (ie_cur && cm.interrupt_mode_bit) s_nxt.ints[c] = 1'b1;
            end else begin
              if (ie_cur) s_nxt.ints[c] = 1'b1;
              if (cm.auto_reinit_enable || cm.auto_buffering_mode) begin
                s_nxt.src[c] = s_r.glb[`SDMA_G_GSA];
                s_nxt.sfc[c][7:0] = s_r.glb[`SDMA_G_GFR][7:0];
                s_nxt.reload_dst = 1'b1;
              end else begin
                s_nxt.en[c] = 1'b0;
              end
            end
          end
        end
      end
      sdma_pkg::ENG_WRITE: if (wr_done) begin
        s_nxt.brp = ~s_r.brp;
        s_nxt.reload_dst = 1'b0;
        s_nxt.dst[c] = s_r.reload_dst ? s_r.glb[`SDMA_G_GDA]
          : s_r.dst[c] + step(cm.dest_index_select, s_r.lastf, s_r.glb);
        if (cm.double_word && !s_r.half) begin
          s_nxt.half = 1'b1;
          s_nxt.eng = sdma_pkg::ENG_READ;
        end else begin
          s_nxt.eng = sdma_pkg::ENG_IDLE;
          s_nxt.last_ch = c;
        end
      end
      default: s_nxt.eng = sdma_pkg::ENG_IDLE;
    endcase
    // Register reads through the subbank window.
    if (REG_ADDR_I == `SDMA_REG_MAIN) rv = {2'b00, s_r.hipri, 2'b00, s_r.en};
    else if (REG_ADDR_I == `SDMA_REG_SBA) rv = {10'h000, s_r.sba};
    else if (sb.hit) begin
      case (sb.fld)
        `SDMA_F_SRC: rv = s_r.src[sb.ch];
        `SDMA_F_DST: rv = s_r.dst[sb.ch];
        `SDMA_F_CTR: rv = s_r.ctr[sb.ch];
        `SDMA_F_SFC: rv = s_r.sfc[sb.ch];
        default: rv = s_r.mcr[sb.ch];
      endcase
    end
    else if (s_r.sba >= `SDMA_SB_GLB && s_r.sba <= `SDMA_SB_GLB_END) rv = s_r.glb[s_r.sba[2:0]];
    else if (s_r.sba == `SDMA_SB_XSRC) rv = {9'h000, s_r.xsrc};
    else if (s_r.sba == `SDMA_SB_XDST) rv = {9'h000, s_r.xdst};
    else if (s_r.sba == `SDMA_SB_STAT) rv = {7'h00, s_r.eng != sdma_pkg::ENG_IDLE, 2'b00, blocked};
    if (REG_RD_I) s_nxt.rdata = rv;
    // Register writes win over engine updates in the same cycle.
    if (REG_WR_I) begin
      if (REG_ADDR_I == `SDMA_REG_MAIN) begin
        s_nxt.en = REG_WDATA_I[5:0];
        s_nxt.hipri = REG_WDATA_I[13:8];
      end else if (REG_ADDR_I == `SDMA_REG_SBA) begin
        s_nxt.sba = REG_WDATA_I[5:0];
      end else if (REG_ADDR_I == `SDMA_REG_SBD || REG_ADDR_I == `SDMA_REG_SBDI) begin
        if (sb.hit) begin
          case (sb.fld)
            `SDMA_F_SRC: s_nxt.src[sb.ch] = REG_WDATA_I;
            `SDMA_F_DST: s_nxt.dst[sb.ch] = REG_WDATA_I;
            `SDMA_F_CTR: s_nxt.ctr[sb.ch] = REG_WDATA_I;
            `SDMA_F_SFC: s_nxt.sfc[sb.ch] = REG_WDATA_I;
            default: s_nxt.mcr[sb.ch] = REG_WDATA_I;
          endcase
        end
        else if (s_r.sba >= `SDMA_SB_GLB && s_r.sba <= `SDMA_SB_GLB_END) s_nxt.glb[s_r.sba[2:0]] = REG_WDATA_I;
        else if (s_r.sba == `SDMA_SB_XSRC) s_nxt.xsrc = REG_WDATA_I[6:0];
        else if (s_r.sba == `SDMA_SB_XDST) s_nxt.xdst = REG_WDATA_I[6:0];
      end
    end
    // The autoincrement window steps the pointer on any access.
    if ((REG_WR_I || REG_RD_I) && REG_ADDR_I == `SDMA_REG_SBDI) s_nxt.sba = s_r.sba + 6'd1;
  end

  // State register.
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) s_r <= '0;
    else s_r <= s_nxt;
  end

  // External cycles meet their floors.
  ext_wr_len_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    $fell(EXT_REQ_O.stb) && $past(EXT_REQ_O.we) |-> $past(EXT_REQ_O.stb, 9))
    else $error("External write shorter than nine cycles.");
  ext_rd_len_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    $fell(EXT_REQ_O.stb) && !$past(EXT_REQ_O.we) |-> $past(EXT_REQ_O.stb, 13))
    else $error("External read shorter than thirteen cycles.");
  hold_grant_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    $rose(BUS_HOLD_GRANT_O) |-> $past(hold_ok) && !EXT_REQ_O.stb)
    else $error("Hold granted over pending transfer.");
  xio_stall_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    CPU_XIO_REQ_I && EXT_REQ_O.stb |-> CPU_XIO_WAIT_O && !CPU_XIO_GNT_O)
    else $error("CPU not stalled during controller cycle.");
  bus_rearb_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    $fell(EXT_REQ_O.stb) && CPU_XIO_REQ_I && !ext_need && !hold_ok |=> CPU_XIO_GNT_O)
    else $error("CPU not granted after controller cycle.");
  frame_dec_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    rd_done && last_el && frc_cur != 8'h00 && !cm.auto_buffering_mode && !REG_WR_I
    |=> s_r.sfc[$past(s_r.ch)][7:0] == $past(frc_cur) - 8'h01)
    else $error("Frame counter did not step down.");
  elem_dec_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    rd_done && !cm.double_word && ctr_cur != 16'h0000 && !REG_WR_I
    |=> s_r.ctr[$past(s_r.ch)] == $past(ctr_cur) - 16'h0001)
    else $error("Element counter did not step down.");
  int_gate_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    |CH_INT_O |-> $past(ie_cur) && $past(rd_done))
    else $error("Interrupt without enable or read.");
  ext_src_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    EXT_REQ_O.stb && !EXT_REQ_O.we |-> cm.src_external_select && s_r.ch == xrd)
    else $error("External read by wrong channel.");
  // The first half of a double word must leave the element count alone.
  dw_half_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    rd_done && cm.double_word && !s_r.half && !REG_WR_I |=> s_r.ctr[$past(s_r.ch)] == $past(ctr_cur))
    else $error("Element counter moved on first half of a double word.");
endmodule : sdma_ctrl

// ===== verification/sdma_mem_model.sv
`timescale 1ns/100ps
// Behavioural far side of the controller: internal RAM and external memory.
module sdma_mem_model (
  input wire logic clk_i, // Clock.
  input wire logic slow_i, // Stretch every answer.
  input wire sdma_pkg::sdma_mem_req_t int_req_i, // Internal request.
  output logic int_ack_o, // Internal access done.
  output logic [15:0] int_rdata_o, // Internal read data.
  input wire sdma_pkg::sdma_ext_req_t ext_req_i, // External cycle.
  output logic ext_rdy_o, // External ready.
  output logic [15:0] ext_rdata_o // External read data.
);
  logic [15:0] imem [256];
  logic [15:0] xmem [256];
  logic [15:0] last_r = 16'h5a5a;
  logic [3:0] wcnt_r = 4'h0;
  logic [3:0] xcnt_r = 4'h0;
  // Known contents so that every moved word can be traced to its source.
  initial for (int i = 0; i < 256; i++) begin
    imem[i] = 16'ha000 + 16'(i);
    xmem[i] = 16'he000 + 16'(i);
  end
  // Slow mode makes the controller hold its request through wait states.
  assign int_ack_o = int_req_i.req && (wcnt_r >= (slow_i ? 4'h2 : 4'h0));
  assign ext_rdy_o = !slow_i || (xcnt_r > 4'he);
  // Outside an answer the data lines toggle, so a stale word is never mistaken for a fresh one.
  assign int_rdata_o = (int_ack_o && !int_req_i.we) ? imem[int_req_i.addr[7:0]] : ~last_r;
  assign ext_rdata_o = (ext_req_i.stb && !ext_req_i.we) ? xmem[ext_req_i.addr[7:0]] : ~last_r;
  // Wait counters and stores.
  always_ff @(posedge clk_i) begin
    wcnt_r <= (!int_req_i.req || int_ack_o) ? 4'h0 : wcnt_r + 4'h1;
    xcnt_r <= !ext_req_i.stb ? 4'h0 : ((xcnt_r == 4'hf) ? xcnt_r : xcnt_r + 4'h1);
    last_r <= int_rdata_o;
    if (int_ack_o && int_req_i.we) imem[int_req_i.addr[7:0]] <= int_req_i.wdata;
    if (ext_req_i.stb && ext_req_i.we && ext_rdy_o) xmem[ext_req_i.addr[7:0]] <= ext_req_i.wdata;
  end
endmodule : sdma_mem_model

// ===== verification/sdma_ctrl_tb.sv
`timescale 1ns/100ps
`include "sdma_params.svh"
module sdma_ctrl_tb;
  logic clk, rst, reg_wr, reg_rd, cpu_int_req, xio_req, hold_req, hold_mode, slow;
  logic int_wait, xio_gnt, xio_wait, hold_gnt, halt, int_ack, ext_rdy;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, sync_evt, int_rdata, ext_rdata, d;
  logic [5:0] ch_int;
  logic [6:0] last_page;
  sdma_pkg::sdma_mem_req_t int_req;
  sdma_pkg::sdma_ext_req_t ext_req;
  int miscompares = 0, n_tests = 0, cycles = 0, stb_len = 0, last_len = 0, i;
  sdma_ctrl uut (.CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(reg_addr), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd),
    .REG_WDATA_I(reg_wdata), .REG_RDATA_O(reg_rdata), .CPU_INT_REQ_I(cpu_int_req), .CPU_INT_WAIT_O(int_wait),
    .INT_REQ_O(int_req), .INT_ACK_I(int_ack), .INT_RDATA_I(int_rdata), .EXT_REQ_O(ext_req), .EXT_RDY_I(ext_rdy),
    .EXT_RDATA_I(ext_rdata), .CPU_XIO_REQ_I(xio_req), .CPU_XIO_GNT_O(xio_gnt), .CPU_XIO_WAIT_O(xio_wait),
    .BUS_HOLD_REQ_I(hold_req), .BUS_HOLD_GRANT_O(hold_gnt), .HOLD_MODE_BIT_I(hold_mode), .CPU_HALT_O(halt),
    .SYNC_EVT_I(sync_evt), .CH_INT_O(ch_int));
  sdma_mem_model mem (.clk_i(clk), .slow_i(slow), .int_req_i(int_req), .int_ack_o(int_ack),
    .int_rdata_o(int_rdata), .ext_req_i(ext_req), .ext_rdy_o(ext_rdy), .ext_rdata_o(ext_rdata));
  // Free-running clock at 25 MHz.
  always #20 clk = ~clk;
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk
  task report_and_stop;
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // Watchdog, external cycle length and bus ownership, sampled mid-cycle where all is settled.
  always @(negedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      report_and_stop();
    end
    if (ext_req.stb) begin
      stb_len++;
      last_page = ext_req.page;
    end else if (stb_len > 0) begin
      last_len = stb_len;
      stb_len = 0;
    end
    if (!rst && cpu_int_req && int_req.req) chk("cpu_int_wait", 16'h0001, {15'h0, int_wait});
    if (!rst) chk("bus_owner", 16'h0000, {15'h0, ext_req.stb & (hold_gnt | xio_gnt)});
    if (!rst && xio_req && ext_req.stb) chk("xio_stalled", 16'h0001, {15'h0, xio_wait});
  end
  task wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
  // Loads one channel context through the autoincrementing data port.
  task chan(input int ch, input logic [15:0] s, input logic [15:0] t, input logic [15:0] n,
    input logic [15:0] f, input logic [15:0] m);
    wr(`SDMA_REG_SBA, 16'(5 * ch));
    wr(`SDMA_REG_SBDI, s);
    wr(`SDMA_REG_SBDI, t);
    wr(`SDMA_REG_SBDI, n);
    wr(`SDMA_REG_SBDI, f);
    wr(`SDMA_REG_SBDI, m);
    wr(`SDMA_REG_MAIN, 16'(1 << ch));
  endtask : chan
  task wait_int(input int ch);
    for (i = 0; i < 600 && ch_int[ch] !== 1'b1; i++) @(negedge clk);
    chk("block_done_int", 16'h0001, {15'h0, ch_int[ch]});
    @(negedge clk);
    // The interrupt comes with the last read, so the closing write is let finish before memory is looked at.
    for (i = 0; i < 40 && (int_req.req || ext_req.stb); i++) @(negedge clk);
    @(negedge clk);
  endtask : wait_int
  task t_regs;
    wr(`SDMA_REG_SBA, 16'h0004);
    rd(`SDMA_REG_SBD);
    chk("mode_reset", 16'h0000, d);
    wr(`SDMA_REG_SBA, 16'h0028);
    wr(`SDMA_REG_SBDI, 16'hffff);
    wr(`SDMA_REG_SBDI, 16'h0009);
    wr(`SDMA_REG_SBA, 16'h0028);
    rd(`SDMA_REG_SBDI);
    chk("src_page", 16'h007f, d);
    rd(`SDMA_REG_SBD);
    chk("dst_page", 16'h0009, d);
    wr(`SDMA_REG_SBA, 16'h001e);
    wr(`SDMA_REG_SBD, 16'h1234);
    rd(`SDMA_REG_SBD);
    chk("unmapped", 16'h0000, d);
    wr(`SDMA_REG_SBA, 16'h0028);
    wr(`SDMA_REG_SBD, 16'h0005);
  endtask : t_regs
  // Two double-word elements with incrementing addresses while the CPU contends and memory is slow.
  task t_int;
    slow <= 1'b1;
    cpu_int_req <= 1'b1;
    chan(0, 16'h0010, 16'h0080, 16'h0001, 16'h0000, 16'h4105);
    wait_int(0);
    @(posedge clk);
    cpu_int_req <= 1'b0;
    chk("int_word3", 16'ha013, mem.imem[8'h83]);
    chk("int_word0", 16'ha010, mem.imem[8'h80]);
    chk("int_word1", 16'ha011, mem.imem[8'h81]);
    rd(`SDMA_REG_MAIN);
    chk("enable_clear", 16'h0000, {10'h0, d[5:0]});
  endtask : t_int
  // Element index on all but the last transfer, frame index on the last, decrement on the other side.
  task t_index;
    slow <= 1'b0;
    wr(`SDMA_REG_SBA, 16'h0020);
    wr(`SDMA_REG_SBDI, 16'h0002);
    wr(`SDMA_REG_SBDI, 16'h0000);
    wr(`SDMA_REG_SBDI, 16'h0005);
    chan(3, 16'h0020, 16'h0090, 16'h0002, 16'h0000, 16'h4308);
    wait_int(3);
    chk("idx_word", 16'ha024, mem.imem[8'h8e]);
    wr(`SDMA_REG_SBA, 16'h000f);
    rd(`SDMA_REG_SBDI);
    chk("src_after", 16'h0029, d);
    rd(`SDMA_REG_SBDI);
    chk("dst_after", 16'h008d, d);
  endtask : t_index
  // One external read with a CPU I/O request waiting, one external write, then a channel with both sides external.
  task t_ext;
    chan(1, 16'h0010, 16'h00a0, 16'h0000, 16'h0000, 16'h4800);
    for (i = 0; i < 20 && ext_req.stb !== 1'b1; i++) @(negedge clk);
    @(posedge clk);
    xio_req <= 1'b1;
    wait_int(1);
    chk("xio_after_dma", 16'h0001, {15'h0, xio_gnt});
    @(posedge clk);
    xio_req <= 1'b0;
    chk("ext_rd_word", 16'he010, mem.imem[8'ha0]);
    chk("ext_rd_len", 16'h0001, {15'h0, last_len >= 13});
    chk("ext_rd_page", 16'h0005, {9'h0, last_page});
    slow <= 1'b1;
    chan(2, 16'h0030, 16'h0040, 16'h0000, 16'h0000, 16'h4020);
    wait_int(2);
    chk("ext_wr_word", 16'ha030, mem.xmem[8'h40]);
    chk("ext_wr_len", 16'h0001, {15'h0, last_len >= 9});
    chk("ext_wr_page", 16'h0009, {9'h0, last_page});
    chan(4, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h4820);
    wr(`SDMA_REG_SBA, 16'h002a);
    rd(`SDMA_REG_SBD);
    chk("both_ext_refused", 16'h0001, {15'h0, d[4]});
    wr(`SDMA_REG_MAIN, 16'h0000);
  endtask : t_ext
  // Two one-element frames, each started by a timer sync event; interrupts at frame end and at block end.
  task t_frames;
    chan(5, 16'h0040, 16'h00b0, 16'h0000, 16'hd001, 16'h6104);
    repeat (8) @(negedge clk);
    chk("sync_gate", 16'ha0b0, mem.imem[8'hb0]);
    repeat (2) begin
      @(posedge clk);
      sync_evt <= 16'h2000;
      @(posedge clk);
      sync_evt <= 16'h0000;
      wait_int(5);
    end
    chk("frame_word0", 16'ha040, mem.imem[8'hb0]);
    chk("frame_word1", 16'ha041, mem.imem[8'hb1]);
  endtask : t_frames
  // Hold grant with both hold modes, then a CPU external cycle.
  task t_hold;
    @(posedge clk);
    hold_mode <= 1'b1;
    hold_req <= 1'b1;
    for (i = 0; i < 20 && hold_gnt !== 1'b1; i++) @(negedge clk);
    chk("hold_grant", 16'h0001, {15'h0, hold_gnt});
    chk("halt_mode1", 16'h0001, {15'h0, halt});
    @(posedge clk);
    hold_mode <= 1'b0;
    @(negedge clk);
    chk("halt_mode0", 16'h0000, {15'h0, halt});
    @(posedge clk);
    hold_req <= 1'b0;
    for (i = 0; i < 20 && hold_gnt !== 1'b0; i++) @(negedge clk);
    @(posedge clk);
    xio_req <= 1'b1;
    for (i = 0; i < 20 && xio_gnt !== 1'b1; i++) @(negedge clk);
    chk("xio_wait", 16'h0000, {15'h0, xio_wait});
    @(posedge clk);
    xio_req <= 1'b0;
  endtask : t_hold
  // Reset, then every scenario in turn.
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {reg_wr, reg_rd, cpu_int_req, xio_req, hold_req, hold_mode, slow} = 7'h00;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    sync_evt = 16'h0000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_int();
    t_index();
    t_ext();
    t_frames();
    t_hold();
    report_and_stop();
  end
endmodule : sdma_ctrl_tb
